// ### src/clock_network_map.vh
// Register indexes, field positions and reset values of the clock network
`ifndef CLOCK_NETWORK_MAP_VH
`define CLOCK_NETWORK_MAP_VH
// Register indexes; byte address is four times the index
`define IDX_GLOBAL 7'h00
`define IDX_REGIONAL 7'h10
`define IDX_EXTOUT 7'h30
`define IDX_ROW 7'h34
`define IDX_LAB 7'h38
`define IDX_IO 7'h3C
`define IDX_STAT_GLOBAL 7'h44
`define IDX_STAT_REGIONAL 7'h45
`define NUM_CFG 7'h44
`define NUM_REGS 7'h46
// Field positions
`define F_SRC_A 0
`define F_SRC_B 8
`define F_DYN 16
`define F_DUAL 16
`define F_PINMODE 16
`define F_VERT 17
`define F_ON 24
`define CFG_RESET 32'h0000_0000
// Source index bounds: pins, synthesiser outputs, internal logic
`define SRC_PIN_TB 6'h08
`define SRC_ENH 6'h0C
`define SRC_FAST 6'h10
`define SRC_CORNER 6'h12
`define SRC_CORE 6'h14
`define SRC_COUNT 6'h24
`define RES_GLOBAL 5'h10
`define RES_COUNT 5'h18
`define ROW_COUNT 3'h6
// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### src/clock_network_select_gate.v
// Clock network source selection, gating and quadrant multiplexing
//
// Notes on behaviour
// [RULE1] Global lines reach all quadrants, any source
// [RULE2] Eight regional lines per quadrant
// [RULE3] Dual-regional: one source, two adjacent quadrants
// [RULE4] Horizontal top/bottom sources, vertical left/right sources
// [RULE5] Corner synthesiser never drives dual-regional
// [RULE6] Quadrant has 16 global plus 8 regional
// [RULE7] Logic block picks three of six rows
// [RULE8] Io region gets eight of twenty-four
// [RULE9] Every line has its own control unit
// [RULE10] Global select follows user logic dynamically
// [RULE11] Static global select reaches any input
// [RULE12] Dynamic choice between any two sources
// [RULE13] Regional and output selects static only
// [RULE14] Regional pins: top/bottom complementary only
// [RULE15] Output pin muxes internal or control unit
// [RULE16] Powered-down network holds its logic low
// [RULE17] Static off bit, unused lines off
// [RULE18] User enable starts/stops clock synchronously
// [RULE19] Enable acts on network, not synthesiser
// [RULE20] Enable sampled while clock is low
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "clock_network_map.vh"

module clock_network_select_gate #(
    parameter ADDR_W = 12
) (
    input wire clk,
    input wire rst_n,
    input wire [11:0] clk_pin_in,
    input wire [7:0] synth_out_in,
    input wire [15:0] core_src_in,
    input wire [3:0] ext_internal_in,
    input wire [15:0] global_sel_in,
    input wire [15:0] global_en_in,
    input wire [31:0] regional_en_in,
    input wire [3:0] ext_en_in,
    output reg [15:0] global_clock_line,
    output reg [31:0] regional_clock_line,
    output reg [3:0] synth_ext_pin,
    output reg [23:0] row_clk,
    output reg [11:0] lab_clk,
    output reg [31:0] io_clk,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ==========================================================
    // Functions
    // ==========================================================
    // Source pick with range guard; out of range reads as idle low
    function src_bit(input [35:0] v, input [5:0] idx);
        begin
            src_bit = (idx < `SRC_COUNT) ? v[idx] : 1'b0;
        end
    endfunction

    // Which sources may form a dual-regional clock in a direction
    function dual_ok(input [5:0] idx, input vert);
        begin
            if (idx >= `SRC_CORE) begin
                dual_ok = 1'b1;
            end else if (vert) begin
                dual_ok = (idx < `SRC_PIN_TB) ||
                    (idx >= `SRC_FAST && idx < `SRC_CORNER);
            end else begin
                dual_ok = (idx >= `SRC_PIN_TB && idx < `SRC_FAST);
            end
        end
    endfunction

    // Regional mux sees top/bottom complementary pins only
    function reg_src_ok(input [5:0] idx);
        begin
            reg_src_ok = (idx >= `SRC_ENH) ||
                (idx >= `SRC_PIN_TB && idx[0]);
        end
    endfunction

    // One of the 24 quadrant resources: globals then regionals
    function res_pick(input [15:0] gv, input [7:0] rv, input [4:0] s);
        begin
            if (s < `RES_GLOBAL)
                res_pick = gv[s[3:0]];
            else if (s < `RES_COUNT)
                res_pick = rv[s[2:0]];
            else
                res_pick = 1'b0;
        end
    endfunction

    // ==========================================================
    // Storage and internal state
    // ==========================================================
    reg [31:0] cfg_reg [0:`NUM_CFG-1];
    reg [11:0] pin_s1_reg;
    reg [11:0] pin_s2_reg;
    reg [7:0] syn_s1_reg;
    reg [7:0] syn_s2_reg;
    reg [15:0] glb_gate_reg;
    reg [15:0] glb_act_reg;
    reg [31:0] reg_gate_reg;
    reg [3:0] ext_gate_reg;
    reg aw_hold_reg;
    reg w_hold_reg;
    reg [ADDR_W-1:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;

    wire [35:0] src_vec;
    reg [15:0] glb_mux;
    reg [15:0] glb_quiet;
    reg [31:0] reg_raw;
    reg [31:0] reg_mux;
    reg [3:0] ext_mux;
    reg [31:0] c;
    reg [31:0] pc;
    integer i;
    integer j;
    integer b;
    integer k;
    integer q;
    integer p;

    // Sources: pins 0..11, synthesiser 12..19, internal 20..35
    assign src_vec = {core_src_in, syn_s2_reg, pin_s2_reg};

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // Pins and synthesiser outputs live outside this clock
    always @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_reg <= 12'h000;
            pin_s2_reg <= 12'h000;
            syn_s1_reg <= 8'h00;
            syn_s2_reg <= 8'h00;
        end else begin
            pin_s1_reg <= clk_pin_in;
            pin_s2_reg <= pin_s1_reg;
            syn_s1_reg <= synth_out_in;
            syn_s2_reg <= syn_s1_reg;
        end
    end

    // ==========================================================
    // Source multiplexers
    // ==========================================================
    // Global, regional and output-pin source selection
    always @* begin
        c = `CFG_RESET;
        pc = `CFG_RESET;
        p = 0;
        for (i = 0; i < 16; i = i + 1) begin
            c = cfg_reg[`IDX_GLOBAL + i];
            // [RULE11] Static any input
            // [RULE12] Two chosen candidates
            glb_quiet[i] = !src_bit(src_vec, c[`F_SRC_A +: 6]) &&
                !src_bit(src_vec, c[`F_SRC_B +: 6]);
            // [RULE10] Dynamic select honoured
            glb_mux[i] = (c[`F_DYN] && glb_act_reg[i]) ?
                src_bit(src_vec, c[`F_SRC_B +: 6]) :
                src_bit(src_vec, c[`F_SRC_A +: 6]);
        end
        for (i = 0; i < 32; i = i + 1) begin
            c = cfg_reg[`IDX_REGIONAL + i];
            // [RULE14] Pin subset filter
            // [RULE13] Static regional select
            reg_raw[i] = reg_src_ok(c[`F_SRC_A +: 6]) &&
                src_bit(src_vec, c[`F_SRC_A +: 6]);
        end
        for (i = 0; i < 32; i = i + 1) begin
            c = cfg_reg[`IDX_REGIONAL + i];
            // Horizontal partner flips quadrant bit 0, vertical bit 1
            p = c[`F_VERT] ? (i ^ 16) : (i ^ 8);
            pc = cfg_reg[`IDX_REGIONAL + p];
            if (c[`F_DUAL]) begin
                // [RULE3] Borrow partner source
                // [RULE4] Direction class check
                // [RULE5] Corner sources refused
                reg_mux[i] = dual_ok(pc[`F_SRC_A +: 6], c[`F_VERT]) &&
                    reg_raw[p];
            end else begin
                reg_mux[i] = reg_raw[i];
            end
        end
        for (i = 0; i < 4; i = i + 1) begin
            c = cfg_reg[`IDX_EXTOUT + i];
            // [RULE13] Static output select
            ext_mux[i] = src_bit(src_vec, c[`F_SRC_A +: 6]);
        end
    end

    // ==========================================================
    // Control units: gating
    // ==========================================================
    // Gates move only while their source is low, so no runt pulse
    always @(posedge clk) begin
        if (!rst_n) begin
            glb_gate_reg <= 16'h0000;
            glb_act_reg <= 16'h0000;
            reg_gate_reg <= 32'h0000_0000;
            ext_gate_reg <= 4'h0;
            global_clock_line <= 16'h0000;
            regional_clock_line <= 32'h0000_0000;
            synth_ext_pin <= 4'h0;
        end else begin
            // [RULE9] One unit per line
            for (j = 0; j < 16; j = j + 1) begin
                // Swap candidates only while both sit low
                if (glb_quiet[j])
                    glb_act_reg[j] <= global_sel_in[j];
                // [RULE20] Enable sampled low
                // [RULE17] Static off bit
                // [RULE18] Synchronous user enable
                if (!glb_mux[j])
                    glb_gate_reg[j] <= cfg_reg[`IDX_GLOBAL + j][`F_ON] &&
                        global_en_in[j];
                // [RULE1] Global line drive
                // [RULE16] Off holds low
                global_clock_line[j] <= glb_mux[j] && glb_gate_reg[j];
            end
            for (j = 0; j < 32; j = j + 1) begin
                // [RULE20] Enable sampled low
                if (!reg_mux[j])
                    reg_gate_reg[j] <=
                        cfg_reg[`IDX_REGIONAL + j][`F_ON] &&
                        regional_en_in[j];
                // [RULE2] Regional line drive
                regional_clock_line[j] <= reg_mux[j] && reg_gate_reg[j];
            end
            for (j = 0; j < 4; j = j + 1) begin
                // [RULE19] Gate after source
                if (!ext_mux[j])
                    ext_gate_reg[j] <= cfg_reg[`IDX_EXTOUT + j][`F_ON] &&
                        ext_en_in[j];
                // [RULE15] Pin dual-purpose mux
                synth_ext_pin[j] <= cfg_reg[`IDX_EXTOUT + j][`F_PINMODE] ?
                    (ext_mux[j] && ext_gate_reg[j]) : ext_internal_in[j];
            end
        end
    end

    // ==========================================================
    // Quadrant resource buses
    // ==========================================================
    // One stage per level; adds fixed latency, never reorders edges
    always @(posedge clk) begin
        if (!rst_n) begin
            row_clk <= 24'h00_0000;
            lab_clk <= 12'h000;
            io_clk <= 32'h0000_0000;
        end else begin
            for (q = 0; q < 4; q = q + 1) begin
                // [RULE6] Twenty-four quadrant resources
                for (k = 0; k < 6; k = k + 1)
                    row_clk[q*6 + k] <= res_pick(global_clock_line,
                        regional_clock_line[q*8 +: 8],
                        cfg_reg[`IDX_ROW + q][k*5 +: 5]);
                // [RULE7] Three of six rows
                for (k = 0; k < 3; k = k + 1)
                    lab_clk[q*3 + k] <=
                        (cfg_reg[`IDX_LAB + q][k*3 +: 3] < `ROW_COUNT) ?
                        row_clk[q*6 + cfg_reg[`IDX_LAB + q][k*3 +: 3]] :
                        1'b0;
                // [RULE8] Eight io clocks
                for (k = 0; k < 8; k = k + 1)
                    io_clk[q*8 + k] <= res_pick(global_clock_line,
                        regional_clock_line[q*8 +: 8],
                        cfg_reg[`IDX_IO + q*2 + k/4][(k%4)*5 +: 5]);
            end
        end
    end

    // ==========================================================
    // Register bus: write channel
    // ==========================================================
    wire [6:0] wr_idx;
    wire wr_hit;
    assign wr_idx = awaddr_reg[8:2];
    assign wr_hit = (awaddr_reg[ADDR_W-1:9] == 0) && (wr_idx < `NUM_CFG);

    // Address and data are held apart, committed once both are in
    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= {ADDR_W{1'b0}};
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            for (b = 0; b < `NUM_CFG; b = b + 1)
                cfg_reg[b] <= `CFG_RESET;
        end else begin
            if (s_axi_awready && s_axi_awvalid) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_hold_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_hold_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_hold_reg && w_hold_reg && !s_axi_bvalid) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                if (wr_hit)
                    for (b = 0; b < 4; b = b + 1)
                        if (wstrb_reg[b])
                            cfg_reg[wr_idx][b*8 +: 8] <= wdata_reg[b*8 +: 8];
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Register bus: read channel
    // ==========================================================
    wire [6:0] rd_idx;
    wire rd_top_ok;
    assign rd_idx = s_axi_araddr[8:2];
    assign rd_top_ok = (s_axi_araddr[ADDR_W-1:9] == 0);

    // Status words show live gate state of every global and regional line
    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                if (!rd_top_ok) begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end else if (rd_idx < `NUM_CFG) begin
                    s_axi_rdata <= cfg_reg[rd_idx];
                end else if (rd_idx == `IDX_STAT_GLOBAL) begin
                    s_axi_rdata <= {16'h0000, glb_gate_reg};
                end else if (rd_idx == `IDX_STAT_REGIONAL) begin
                    s_axi_rdata <= reg_gate_reg;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end else if (!s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### test/clock_network_select_gate_properties.sv
// Checker of bus handshakes and clock outputs of the clock network block
`timescale 1ns/1ps
`default_nettype none
`include "clock_network_map.vh"
module clock_network_select_gate_properties #(
    parameter ADDR_W = 12
) (
    input wire clk,
    input wire rst_n,
    input wire [15:0] global_clock_line,
    input wire [31:0] regional_clock_line,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Reset and configuration bus
    quiet_reset_a: assert property (
        $rose(rst_n) |-> global_clock_line == 16'h0000 &&
        regional_clock_line == 32'h0000_0000 && !s_axi_awready)
        else $error("clock outputs not off after reset");
    write_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped early");
    read_prompt_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_prompt_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    refused_zero_a: assert property (
        s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 0)
        else $error("refused read returned data");
    one_write_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    one_read_a: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
endmodule
bind clock_network_select_gate clock_network_select_gate_properties #(
    .ADDR_W(ADDR_W)
) props_inst (
    .clk(clk), .rst_n(rst_n),
    .global_clock_line(global_clock_line),
    .regional_clock_line(regional_clock_line),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// ### test/user_logic_model.sv
// Model of the user logic feeding sources, selects and enables
`timescale 1ns/1ps
`default_nettype none
module user_logic_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] gen,
    input wire logic [15:0] gsel,
    input wire logic [31:0] ren,
    output logic [11:0] clk_pin_in,
    output logic [7:0] synth_out_in,
    output logic [15:0] core_src_in,
    output logic [3:0] ext_internal_in,
    output logic [15:0] global_sel_in,
    output logic [15:0] global_en_in,
    output logic [31:0] regional_en_in,
    output logic [3:0] ext_en_in
);
    logic [3:0] cnt_reg;
    // ==========================================================
    // Sources: even bits toggle at twice the rate of odd bits
    always_ff @(posedge clk) begin
        cnt_reg <= rst_n ? cnt_reg + 4'h1 : 4'h0;
    end
    assign core_src_in = {8{cnt_reg[2], cnt_reg[1]}};
    assign clk_pin_in = {6{cnt_reg[2], cnt_reg[1]}};
    assign synth_out_in = {4{cnt_reg[2], cnt_reg[1]}};
    assign ext_internal_in = cnt_reg;
    // selects and enables change on clock
    always_ff @(posedge clk) begin
        global_sel_in <= gsel;
        global_en_in <= gen;
        regional_en_in <= ren;
        ext_en_in <= ren[3:0];
    end
endmodule
`default_nettype wire

// ### test/test_clock_network_select_gate.sv
// Self-checking bench for the clock network select and gate block
`timescale 1ns/1ps
`default_nettype none
module test_clock_network_select_gate;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] gen = 16'h0000, gsel = 16'h0000;
    logic [31:0] ren = 32'h0000_0000;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, regional_clock_line, regional_en_in, io_clk;
    wire [11:0] clk_pin_in, lab_clk;
    wire [23:0] row_clk;
    wire [7:0] synth_out_in;
    wire [15:0] core_src_in, global_sel_in, global_en_in;
    wire [15:0] global_clock_line;
    wire [3:0] ext_internal_in, ext_en_in, synth_ext_pin;
    integer failures = 0, num_checks = 0, cycles = 0, n;
    logic [31:0] d;
    logic [1:0] r;
    // ==========================================================
    // Clock, watchdog and instances
    always #2 clk = ~clk;
    // Cut a hung handshake short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            close_out;
        end
    end
    user_logic_model user_logic_model_inst (.clk(clk), .rst_n(rst_n),
        .gen(gen), .gsel(gsel), .ren(ren), .clk_pin_in(clk_pin_in),
        .synth_out_in(synth_out_in), .core_src_in(core_src_in),
        .ext_internal_in(ext_internal_in), .global_sel_in(global_sel_in),
        .global_en_in(global_en_in), .regional_en_in(regional_en_in),
        .ext_en_in(ext_en_in));
    clock_network_select_gate clock_network_select_gate_inst (.clk(clk),
        .rst_n(rst_n), .clk_pin_in(clk_pin_in),
        .synth_out_in(synth_out_in), .core_src_in(core_src_in),
        .ext_internal_in(ext_internal_in), .global_sel_in(global_sel_in),
        .global_en_in(global_en_in), .regional_en_in(regional_en_in),
        .ext_en_in(ext_en_in), .global_clock_line(global_clock_line),
        .regional_clock_line(regional_clock_line),
        .synth_ext_pin(synth_ext_pin), .row_clk(row_clk),
        .lab_clk(lab_clk), .io_clk(io_clk),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    // ==========================================================
    // Shared tasks
    task check(input logic [31:0] got, input logic [31:0] exp,
               input string what);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Write: address and data offered together, each dropped when taken
    task axi_wr(input logic [11:0] a, input logic [31:0] v);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw_done = 1;
                s_axi_awvalid <= 0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w_done = 1;
                s_axi_wvalid <= 0;
            end
        end
        @(posedge clk);
        while (s_axi_bvalid !== 1'b1) @(posedge clk);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task axi_rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        @(posedge clk);
        while (s_axi_arready !== 1'b1) @(posedge clk);
        s_axi_arvalid <= 0;
        @(posedge clk);
        while (s_axi_rvalid !== 1'b1) @(posedge clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    // Settle, then count edges of one line over 32 cycles
    function logic pick(input integer g, i);
        case (g)
            0: pick = global_clock_line[i];
            1: pick = regional_clock_line[i];
            2: pick = row_clk[i];
            3: pick = lab_clk[i];
            4: pick = io_clk[i];
            default: pick = synth_ext_pin[i];
        endcase
    endfunction
    task count(input integer g, input integer i);
        logic prev, cur;
        repeat (12) @(posedge clk);
        n = 0;
        prev = pick(g, i);
        repeat (32) begin
            @(posedge clk);
            cur = pick(g, i);
            if (cur !== prev)
                n = n + 1;
            prev = cur;
        end
    endtask
    // ==========================================================
    // Scenarios
    task t_static;
        axi_rd(12'h110);
        check(d, 32'h0000_0000, "gates at reset");
        axi_wr(12'h000, 32'h0100_0014);
        @(posedge clk);
        gen <= 16'h0001;
        count(0, 0);
        check({31'h0, n >= 14}, 1, "static fast source");
        axi_rd(12'h110);
        check(d[0], 1, "gate status on");
        @(posedge clk);
        gen <= 16'h0000;
        count(0, 0);
        check(n, 0, "disabled edges");
        check(global_clock_line[0], 0, "disabled level");
        @(posedge clk);
        gen <= 16'h0001;
        axi_wr(12'h000, 32'h0000_0014);
        count(0, 0);
        check(n, 0, "static off edges");
    endtask
    task t_dynamic;
        axi_wr(12'h004, 32'h0101_1514);
        @(posedge clk);
        gen <= 16'h0002;
        count(0, 1);
        check({31'h0, n >= 14}, 1, "candidate A");
        @(posedge clk);
        gsel <= 16'h0002;
        count(0, 1);
        check({31'h0, n >= 6 && n <= 9}, 1, "candidate B");
    endtask
    task t_regional;
        ren <= 32'hffff_ffff;
        axi_wr(12'h040, 32'h0100_0009);
        axi_wr(12'h060, 32'h0101_0000);
        count(1, 0);
        check({31'h0, n >= 6}, 1, "regional pin");
        count(1, 8);
        check({31'h0, n >= 6}, 1, "dual horizontal");
        axi_wr(12'h040, 32'h0100_0012);
        count(1, 8);
        check(n, 0, "dual from corner");
        axi_wr(12'h040, 32'h0100_0000);
        count(1, 0);
        check(n, 0, "regional side pin");
    endtask
    task t_bus;
        axi_wr(12'h008, 32'h0100_0715);
        axi_rd(12'h008);
        check(d, 32'h0100_0715, "readback");
        axi_wr(12'h118, 32'h0000_0001);
        check(r, 2'b10, "unmapped write");
        axi_wr(12'h110, 32'h0000_0001);
        check(r, 2'b10, "status write");
        axi_rd(12'h118);
        check(r, 2'b10, "unmapped read resp");
        check(d, 32'h0000_0000, "unmapped read data");
    endtask
    // Row, lab and io buses from global 1, then output pin 0
    task t_tree;
        axi_wr(12'h0D0, 32'h0000_0001);
        axi_wr(12'h0F0, 32'h0000_0001);
        count(2, 0);
        check({31'h0, n >= 6}, 1, "row clock");
        count(3, 0);
        check({31'h0, n >= 6}, 1, "lab clock");
        count(4, 0);
        check({31'h0, n >= 6}, 1, "io clock");
        count(5, 0);
        check(n, 32, "pin internal");
        axi_wr(12'h0C0, 32'h0101_0014);
        count(5, 0);
        check({31'h0, n >= 14}, 1, "pin gated");
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(global_clock_line, 16'h0000, "lines at reset");
        t_static;
        t_dynamic;
        t_regional;
        t_bus;
        t_tree;
        close_out;
    end
endmodule
`default_nettype wire
